// ---- core/tlbt_pkg.sv ----
// Shared constants for the TLB test access block: operation codes,
// field positions, RAM lane layout and reset values.
// Assumes the coprocessor operation fields arrive already split apart.
package tlbt_pkg;

    // ****************************************
    // Operation decode
    // ****************************************
    localparam logic [3:0] CRN_TEST    = 4'hF;
    localparam logic [3:0] CRM_SELECT  = 4'h1;
    localparam logic [3:0] CRM_TAG_RD  = 4'h2;
    localparam logic [3:0] CRM_TAG_WR  = 4'h3;
    localparam logic [3:0] CRM_XL_RD   = 4'h4;
    localparam logic [3:0] CRM_XL_WR   = 4'h5;
    localparam logic [3:0] CRM_XFER    = 4'h7;
    localparam logic [2:0] OP1_SELECT  = 3'h0;
    localparam logic [2:0] OP1_TEST_A  = 3'h4;
    localparam logic [2:0] OP1_TEST_B  = 3'h5;
    localparam logic [2:0] OP2_MAIN    = 3'h0;
    localparam logic [2:0] OP2_LOCK    = 3'h1;

    // ****************************************
    // Word field positions
    // ****************************************
    localparam int SEL_WAY_BIT   = 31;
    localparam int SEL_IDX_MSB   = 14;
    localparam int SEL_IDX_LSB   = 10;
    localparam int LK_IDX_MSB    = 28;
    localparam int LK_IDX_LSB    = 26;
    localparam int ADDR_MSB      = 31;
    localparam int ADDR_LSB      = 10;
    localparam int TAG_VALID_BIT = 4;
    localparam int SIZE_MSB      = 3;
    localparam int ATTR_MSB      = 7;

    // Entry size codes and access permission codes
    localparam logic [3:0] SIZE_1KB  = 4'h1;
    localparam logic [3:0] SIZE_4KB  = 4'h3;
    localparam logic [3:0] SIZE_16KB = 4'h5;
    localparam logic [3:0] SIZE_64KB = 4'h7;
    localparam logic [3:0] SIZE_1MB  = 4'hB;
    localparam logic [1:0] AP_NONE   = 2'h0;
    localparam logic [1:0] AP_PRIV   = 2'h1;
    localparam logic [1:0] AP_USR_RO = 2'h2;
    localparam logic [1:0] AP_FULL   = 2'h3;

    // ****************************************
    // RAM layout
    // ****************************************
    localparam int RAM_WIDTH   = 112;
    localparam int ENTRY_WIDTH = 56;
    localparam int IDX_WIDTH   = 5;
    localparam int LK_WIDTH    = 3;
    localparam int LK_ENTRIES  = 8;
    localparam int MAIN_SLOTS  = 64;
    localparam logic [3:0] LANES_READ = 4'h0;
    localparam logic [3:0] LANES_WAY0 = 4'h3;
    localparam logic [3:0] LANES_WAY1 = 4'hC;
    localparam logic [31:0] REG_RESET = 32'h0000_0000;

endpackage

// ---- core/tlbt_ram_if.sv ----
// Request/answer bundle between the operation decoder and the RAM sequencer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface tlbt_ram_if;
    logic        req;      // One-cycle request
    logic        wr;       // Write when high, read when low
    logic        way;      // Way select
    logic [4:0]  index;    // Row index
    logic [55:0] entry;    // Packed entry to write
    logic        done;     // One-cycle completion
    logic [55:0] rdEntry;  // Selected way lane on read

    modport ctrl (output req, output wr, output way, output index, output entry,
                  input done, input rdEntry);
    modport ram  (input req, input wr, input way, input index, input entry,
                  output done, output rdEntry);
endinterface
`default_nettype wire

// ---- core/tlbt_ram_port.sv ----
// RAM sequencer: drives select, index, lane enables and write bus of the
// main TLB data RAM. Assumes a RAM that captures on the edge where select
// is high and presents read data in the following cycle.
`timescale 1ns/1ps
`default_nettype none
module tlbt_ram_port (
    input  wire logic          clk,                // System clock
    input  wire logic          reset_n,            // Async reset, active low
    tlbt_ram_if.ram            ramIf,              // Decoder side
    output logic               tlbRamSelect,       // RAM chip select
    output logic [4:0]         tlbRamIndexBus,     // RAM row index
    output logic [3:0]         tlbRamLaneWrite,    // Lane write enables
    output logic [111:0]       tlbRamWriteBus,     // Write data
    output logic               tlbRamOutputEnable, // RAM output enable
    input  wire logic [111:0]  tlbRamReadBus       // Read data
);
    typedef enum logic [3:0] {P_IDLE = 4'b0001, P_WRITE = 4'b0010,
                              P_READ = 4'b0100, P_SAMPLE = 4'b1000} tlbt_port_e;
    tlbt_port_e  stQ, stD;
    logic        selQ, selD, wayQ, wayD;
    logic [4:0]  idxQ, idxD;
    logic [3:0]  laneQ, laneD;
    logic [111:0] wdQ, wdD;

    // Held on for the main RAM, never toggled per access
    assign tlbRamOutputEnable = 1'b1;
    assign tlbRamSelect       = selQ;
    assign tlbRamIndexBus     = idxQ;
    assign tlbRamLaneWrite    = laneQ;
    assign tlbRamWriteBus     = wdQ;
    assign ramIf.done         = (stQ == P_WRITE) || (stQ == P_SAMPLE);
    // Read bus is only looked at by the decoder in the sample cycle
    assign ramIf.rdEntry = wayQ ? tlbRamReadBus[111:56] : tlbRamReadBus[55:0];

    // Next pin values: select stands exactly one cycle per access
    always_comb
    begin
        stD   = stQ;
        selD  = 1'b0;
        laneD = tlbt_pkg::LANES_READ;
        idxD  = idxQ;
        wdD   = wdQ;
        wayD  = wayQ;
        case (stQ)
            P_IDLE:
                if (ramIf.req)
                begin
                    selD = 1'b1;
                    idxD = ramIf.index;
                    wayD = ramIf.way;
                    if (ramIf.wr)
                    begin
                        laneD = ramIf.way ? tlbt_pkg::LANES_WAY1 : tlbt_pkg::LANES_WAY0;
                        wdD   = {ramIf.entry, ramIf.entry};
                        stD   = P_WRITE;
                    end
                    else
                        stD = P_READ;
                end
            P_WRITE:  stD = P_IDLE;
            P_READ:   stD = P_SAMPLE;
            P_SAMPLE: stD = P_IDLE;
            default:  stD = P_IDLE;
        endcase
    end

    // Pin registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stQ   <= P_IDLE;
            selQ  <= 1'b0;
            wayQ  <= 1'b0;
            idxQ  <= 5'h00;
            laneQ <= 4'h0;
            wdQ   <= '0;
        end
        else
        begin
            stQ   <= stD;
            selQ  <= selD;
            wayQ  <= wayD;
            idxQ  <= idxD;
            laneQ <= laneD;
            wdQ   <= wdD;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    write_strobe_a: assert property (ramIf.req && ramIf.wr |=> tlbRamSelect && |tlbRamLaneWrite ##1 !tlbRamSelect)
        else $error("write select not a single cycle");
    replicate_a: assert property (tlbRamSelect |-> tlbRamWriteBus[111:56] == tlbRamWriteBus[55:0])
        else $error("way lanes differ");
    read_lanes_a: assert property (ramIf.req && !ramIf.wr |=> tlbRamSelect && tlbRamLaneWrite == 4'h0 ##1 ramIf.done)
        else $error("read access malformed");
    index_follow_a: assert property (ramIf.req |=> tlbRamIndexBus == $past(ramIf.index))
        else $error("index bus wrong");
    oe_held_a: assert property (tlbRamOutputEnable)
        else $error("output enable dropped");
endmodule
`default_nettype wire

// ---- core/tlbt_test_access.sv ----
// TLB test access port: decodes coprocessor test operations, holds the
// entry select and the two storage words, the lockdown entries, and
// commits main TLB entries to the external data RAM.
// Assumes one operation at a time, offered while copReady is high.
`timescale 1ns/1ps
`default_nettype none
module tlbt_test_access (
    input  wire logic          clk,                // System clock, 10 MHz
    input  wire logic          reset_n,            // Async reset, active low
    input  wire logic          copValid,           // Operation offered
    output logic               copReady,           // Operation can be taken
    input  wire logic          copWrite,           // High for register write
    input  wire logic [2:0]    copOpcode1,         // Opcode_1 field
    input  wire logic [3:0]    copCrn,             // CRn field
    input  wire logic [3:0]    copCrm,             // CRm field
    input  wire logic [2:0]    copOpcode2,         // Opcode_2 field
    input  wire logic [31:0]   copWdata,           // Write data
    output logic               copDone,            // Operation completed
    output logic [31:0]        copRdata,           // Read data
    output logic               tlbRamSelect,       // RAM chip select
    output logic [4:0]         tlbRamIndexBus,     // RAM row index
    output logic [3:0]         tlbRamLaneWrite,    // Lane write enables
    output logic [111:0]       tlbRamWriteBus,     // RAM write data
    output logic               tlbRamOutputEnable, // RAM output enable
    input  wire logic [111:0]  tlbRamReadBus       // RAM read data
);
    typedef enum logic [1:0] {TLBT_IDLE = 2'b01, TLBT_RAM = 2'b10} tlbt_state_e;

    tlbt_ram_if ramIf();

    // ****************************************
    // State
    // ****************************************
    tlbt_state_e stQ, stD;
    logic        selWayQ, selWayD;
    logic [4:0]  selIdxQ, selIdxD;
    logic [2:0]  lkIdxQ, lkIdxD;
    logic [31:0] tagQ, tagD;
    logic [31:0] xlatQ, xlatD;
    logic [31:0] rdataQ, rdataD;
    logic        doneQ, doneD;
    logic        rdXlatQ, rdXlatD;
    logic        opWrQ, opWrD;
    logic [31:0] lkTagQ [tlbt_pkg::LK_ENTRIES];
    logic [31:0] lkXlatQ [tlbt_pkg::LK_ENTRIES];
    logic [tlbt_pkg::MAIN_SLOTS-1:0] validQ;
    logic        lkWe, validWe, ramReq, ramWr;
    logic        take, isSel, isTest, isLock;
    logic [31:0] selWord;
    logic [55:0] rdE;
    logic [5:0]  slot;

    // ****************************************
    // Decode
    // ****************************************
    // Only one operation in flight; a RAM access blocks the next one
    assign copReady = (stQ == TLBT_IDLE);
    assign take     = copValid && copReady;
    assign isSel    = (copCrn == tlbt_pkg::CRN_TEST) && (copOpcode1 == tlbt_pkg::OP1_SELECT)
                   && (copCrm == tlbt_pkg::CRM_SELECT) && (copOpcode2 == tlbt_pkg::OP2_MAIN);
    assign isTest   = (copCrn == tlbt_pkg::CRN_TEST)
                   && ((copOpcode1 == tlbt_pkg::OP1_TEST_A) || (copOpcode1 == tlbt_pkg::OP1_TEST_B))
                   && ((copOpcode2 == tlbt_pkg::OP2_MAIN) || (copOpcode2 == tlbt_pkg::OP2_LOCK));
    assign isLock   = (copOpcode2 == tlbt_pkg::OP2_LOCK);
    // Select readback shows both index formats; they do not overlap
    assign selWord  = {selWayQ, 2'b00, lkIdxQ, 11'h000, selIdxQ, 10'h000};
    assign slot     = {selWayQ, selIdxQ};
    assign rdE      = ramIf.rdEntry;

    // Entry packing onto one 56-bit way lane, way chosen by lane enables
    assign ramIf.req   = ramReq;
    assign ramIf.wr    = ramWr;
    assign ramIf.way   = selWayQ;
    assign ramIf.index = selIdxQ;
    assign ramIf.entry = {tagQ[tlbt_pkg::ADDR_MSB:tlbt_pkg::ADDR_LSB], tagQ[tlbt_pkg::SIZE_MSB:0],
                          xlatQ[tlbt_pkg::ADDR_MSB:tlbt_pkg::ADDR_LSB], xlatQ[tlbt_pkg::ATTR_MSB:0]};
    assign copDone  = doneQ;
    assign copRdata = rdataQ;

    // ****************************************
    // Operation sequencing
    // ****************************************
    // Next values of all control state; writes drop should-be-zero bits
    always_comb
    begin
        stD     = stQ;
        selWayD = selWayQ;
        selIdxD = selIdxQ;
        lkIdxD  = lkIdxQ;
        tagD    = tagQ;
        xlatD   = xlatQ;
        rdataD  = rdataQ;
        doneD   = 1'b0;
        rdXlatD = rdXlatQ;
        opWrD   = opWrQ;
        lkWe    = 1'b0;
        validWe = 1'b0;
        ramReq  = 1'b0;
        ramWr   = 1'b0;
        case (stQ)
            TLBT_IDLE:
                if (take)
                begin
                    doneD = 1'b1;
                    if (isSel)
                    begin
                        if (copWrite)
                        begin
                            selWayD = copWdata[tlbt_pkg::SEL_WAY_BIT];
                            selIdxD = copWdata[tlbt_pkg::SEL_IDX_MSB:tlbt_pkg::SEL_IDX_LSB];
                            lkIdxD  = copWdata[tlbt_pkg::LK_IDX_MSB:tlbt_pkg::LK_IDX_LSB];
                        end
                        else
                            rdataD = selWord;
                    end
                    else if (isTest)
                    begin
                        case (copCrm)
                            tlbt_pkg::CRM_TAG_WR:
                                if (copWrite)
                                    tagD = {copWdata[31:10], 5'h00, copWdata[4:0]};
                            tlbt_pkg::CRM_XL_WR:
                                if (copWrite)
                                    xlatD = {copWdata[31:10], 2'b00, copWdata[7:0]};
                            tlbt_pkg::CRM_TAG_RD, tlbt_pkg::CRM_XL_RD:
                                if (!copWrite)
                                begin
                                    rdXlatD = (copCrm == tlbt_pkg::CRM_XL_RD);
                                    if (isLock)
                                        rdataD = rdXlatD ? lkXlatQ[lkIdxQ] : lkTagQ[lkIdxQ];
                                    else
                                    begin
                                        ramReq = 1'b1;
                                        opWrD  = 1'b0;
                                        doneD  = 1'b0;
                                        stD    = TLBT_RAM;
                                    end
                                end
                            tlbt_pkg::CRM_XFER:
                                if (copWrite)
                                begin
                                    if (isLock)
                                        lkWe = 1'b1;
                                    else
                                    begin
                                        ramReq  = 1'b1;
                                        ramWr   = 1'b1;
                                        validWe = 1'b1;
                                        opWrD   = 1'b1;
                                        doneD   = 1'b0;
                                        stD     = TLBT_RAM;
                                    end
                                end
                            default: rdataD = tlbt_pkg::REG_RESET;
                        endcase
                    end
                    else
                        rdataD = tlbt_pkg::REG_RESET;
                end
            TLBT_RAM:
                if (ramIf.done)
                begin
                    doneD = 1'b1;
                    stD   = TLBT_IDLE;
                    if (!opWrQ)
                        rdataD = rdXlatQ ? {rdE[29:8], 2'b00, rdE[7:0]}
                                         : {rdE[55:34], 5'h00, validQ[slot], rdE[33:30]};
                end
            default: stD = TLBT_IDLE;
        endcase
    end

    // Control registers
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stQ     <= TLBT_IDLE;
            selWayQ <= 1'b0;
            selIdxQ <= 5'h00;
            lkIdxQ  <= 3'h0;
            tagQ    <= tlbt_pkg::REG_RESET;
            xlatQ   <= tlbt_pkg::REG_RESET;
            rdataQ  <= tlbt_pkg::REG_RESET;
            doneQ   <= 1'b0;
            rdXlatQ <= 1'b0;
            opWrQ   <= 1'b0;
        end
        else
        begin
            stQ     <= stD;
            selWayQ <= selWayD;
            selIdxQ <= selIdxD;
            lkIdxQ  <= lkIdxD;
            tagQ    <= tagD;
            xlatQ   <= xlatD;
            rdataQ  <= rdataD;
            doneQ   <= doneD;
            rdXlatQ <= rdXlatD;
            opWrQ   <= opWrD;
        end
    end

    // Lockdown entries and main valid bits; the RAM has no lane for valid
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            validQ <= '0;
            for (int i = 0; i < tlbt_pkg::LK_ENTRIES; i++)
            begin
                lkTagQ[i]  <= tlbt_pkg::REG_RESET;
                lkXlatQ[i] <= tlbt_pkg::REG_RESET;
            end
        end
        else
        begin
            if (lkWe)
            begin
                lkTagQ[lkIdxQ]  <= tagQ;
                lkXlatQ[lkIdxQ] <= xlatQ;
            end
            if (validWe)
                validQ[slot] <= tagQ[tlbt_pkg::TAG_VALID_BIT];
        end
    end

    // ****************************************
    // RAM sequencer
    // ****************************************
    // Read bus needs no synchroniser: the RAM shares this clock
    tlbt_ram_port u_ram_port (
        .clk                (clk),
        .reset_n            (reset_n),
        .ramIf              (ramIf),
        .tlbRamSelect       (tlbRamSelect),
        .tlbRamIndexBus     (tlbRamIndexBus),
        .tlbRamLaneWrite    (tlbRamLaneWrite),
        .tlbRamWriteBus     (tlbRamWriteBus),
        .tlbRamOutputEnable (tlbRamOutputEnable),
        .tlbRamReadBus      (tlbRamReadBus)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sel_fields_a: assert property (take && isSel && copWrite |=> selWayQ == $past(copWdata[31])
                                   && selIdxQ == $past(copWdata[14:10]) && lkIdxQ == $past(copWdata[28:26]))
        else $error("select fields not captured");
    tag_mask_a: assert property (take && isTest && copWrite && copCrm == 4'h3 |=> tagQ[9:5] == 5'h00
                                 && tagQ[31:10] == $past(copWdata[31:10]) && tagQ[4:0] == $past(copWdata[4:0]))
        else $error("tag word wrong");
    xlat_mask_a: assert property (take && isTest && copWrite && copCrm == 4'h5 |=> xlatQ[9:8] == 2'b00
                                  && xlatQ[7:0] == $past(copWdata[7:0]))
        else $error("translation word wrong");
    main_commit_a: assert property (take && isTest && !isLock && copWrite && copCrm == 4'h7
                                    |=> tlbRamSelect && tlbRamIndexBus == selIdxQ
                                    && tlbRamWriteBus[55:0] == ramIf.entry ##1 copDone)
        else $error("main transfer not committed in two cycles");
    lane_way_a: assert property (tlbRamSelect && |tlbRamLaneWrite |-> tlbRamLaneWrite == (selWayQ ? 4'hC : 4'h3))
        else $error("lane enables do not match way");
    main_read_a: assert property (take && isTest && !isLock && !copWrite && copCrm == 4'h2
                                  |=> !copDone [*2] ##1 copDone)
        else $error("main tag read latency wrong");
    lock_write_a: assert property (take && isLock && isTest && copWrite && copCrm == 4'h7
                                   |=> lkTagQ[$past(lkIdxQ)] == $past(tagQ) && copDone)
        else $error("lockdown transfer lost");
    undecoded_zero_a: assert property (take && !isSel && !isTest |=> copDone && copRdata == 32'h0000_0000)
        else $error("undecoded operation left read data");
    lock_read_a: assert property (take && isTest && isLock && !copWrite && copCrm == 4'h2
                                  |=> copDone && copRdata == lkTagQ[lkIdxQ])
        else $error("lockdown tag read wrong");

    main_xfer_c: cover property (take && isTest && !isLock && copCrm == 4'h7 && copWrite);
    lock_read_c: cover property (take && isTest && isLock && copCrm == 4'h4 && !copWrite);
    section_c: cover property (tagQ[3:0] == tlbt_pkg::SIZE_1MB && xlatQ[3:2] == tlbt_pkg::AP_FULL);
    way1_c: cover property (tlbRamSelect && tlbRamLaneWrite == 4'hC);
endmodule
`default_nettype wire

// ---- testbench/tlbt_ram_model.sv ----
// Behavioural data RAM for the main TLB, 32 rows of 112 bits.
// Assumes one access per select pulse, same clock as the sequencer.
`timescale 1ns/1ps
`default_nettype none
module tlbt_ram_model (
    input  wire logic         clk,       // System clock
    input  wire logic         ramSelect, // Chip select
    input  wire logic [4:0]   ramIndex,  // Row index
    input  wire logic [3:0]   laneWrite, // Lane write enables
    input  wire logic [111:0] writeBus,  // Write data
    output logic      [111:0] readBus    // Read data
);
    logic [111:0] rows [32];
    logic [111:0] lastRow;
    logic         readNow;
    logic [111:0] laneMask;
    initial
    begin
        foreach (rows[i]) rows[i] = '0;
        readNow = 1'b0;
        lastRow = '0;
    end
    // Bit 56 is in no lane, so it is never written
    assign laneMask = {{26{laneWrite[3]}}, {29{laneWrite[2]}}, 1'b0, {26{laneWrite[1]}}, {30{laneWrite[0]}}};
    // Capture on the select edge; read data answers in the next cycle
    always @(posedge clk)
    begin
        readNow <= ramSelect && laneWrite == 4'h0;
        if (ramSelect)
        begin
            rows[ramIndex] <= (rows[ramIndex] & ~laneMask) | (writeBus & laneMask);
            lastRow <= rows[ramIndex];
        end
    end
    // Always driven; outside the answer cycle the old data is inverted
    assign readBus = readNow ? lastRow : ~lastRow;
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// Self-checking bench for the TLB test access block.
// Assumes the RAM model answers one cycle after a read select.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, resetN, copValid, copReady, copWrite, copDone, ramSel, ramOe, way;
    logic [2:0] copOpcode1, copOpcode2, t1, lk;
    logic [3:0] copCrn, copCrm, ramLane, capLane;
    logic [4:0] ramIdx, capIdx, idx;
    logic [31:0] copWdata, copRdata, seed = 32'h50, tag, xl;
    logic [55:0] ent;
    logic [111:0] ramWbus, ramRbus, capBus;
    logic [3:0] sizes [5] = '{4'h1, 4'h3, 4'h5, 4'h7, 4'hB};
    int failures = 0, totalChecks = 0, cycles = 0;
    // Reference model state, kept from the rules alone
    logic [31:0] mTag = '0, mXl = '0, r;
    logic [31:0] mainTag [64] = '{default: 32'h0};
    logic [31:0] mainXl [64] = '{default: 32'h0};
    logic [31:0] lkTag [8] = '{default: 32'h0};
    logic [31:0] lkXl [8] = '{default: 32'h0};
    logic [31:0] expQ [$];
    logic mWay = 1'b0;
    logic [4:0] mIdx = 5'h00;
    logic [2:0] mLk = 3'h0;
    int mLat;
    tlbt_test_access DUT (.clk(clk), .reset_n(resetN), .copValid(copValid), .copReady(copReady),
        .copWrite(copWrite), .copOpcode1(copOpcode1), .copCrn(copCrn), .copCrm(copCrm),
        .copOpcode2(copOpcode2), .copWdata(copWdata), .copDone(copDone), .copRdata(copRdata),
        .tlbRamSelect(ramSel), .tlbRamIndexBus(ramIdx), .tlbRamLaneWrite(ramLane),
        .tlbRamWriteBus(ramWbus), .tlbRamOutputEnable(ramOe), .tlbRamReadBus(ramRbus));
    tlbt_ram_model ram (.clk(clk), .ramSelect(ramSel), .ramIndex(ramIdx), .laneWrite(ramLane),
        .writeBus(ramWbus), .readBus(ramRbus));
    always #50 clk = ~clk;
    // Latch each RAM write so it can be checked after the op completes
    always @(posedge clk)
        if (ramSel === 1'b1 && ramLane !== 4'h0)
        begin
            capBus <= ramWbus;
            capLane <= ramLane;
            capIdx <= ramIdx;
        end
    // Hang guard, far above the hundred or so cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            final_report();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic checkVal(input logic [111:0] got, input logic [111:0] exp, input string msg);
        totalChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask
    // Reference model: predicts latency and read data; way 1 loses its B bit, no lane holds bit 56
    task automatic model(input logic wr, input logic [2:0] o1, input logic [3:0] crm, input logic [2:0] o2,
                         input logic [31:0] d);
        logic [5:0] s;
        s = {mWay, mIdx};
        mLat = 0;
        if (o1 == 3'h0 && crm == 4'h1 && o2 == 3'h0)
        begin
            if (wr)
                {mWay, mIdx, mLk} = {d[31], d[14:10], d[28:26]};
            else
                expQ.push_back({mWay, 2'h0, mLk, 11'h000, mIdx, 10'h000});
        end
        else if ((o1 == 3'h4 || o1 == 3'h5) && o2 < 3'h2)
        begin
            case (crm)
                4'h2, 4'h4:
                    if (!wr)
                    begin
                        mLat = o2[0] ? 0 : 2;
                        if (o2[0])
                            expQ.push_back(crm == 4'h2 ? lkTag[mLk] : lkXl[mLk]);
                        else
                            expQ.push_back(crm == 4'h2 ? mainTag[s] : mainXl[s]);
                    end
                4'h3:
                    if (wr)
                        mTag = d & 32'hFFFF_FC1F;
                4'h5:
                    if (wr)
                        mXl = d & 32'hFFFF_FCFF;
                4'h7:
                    if (wr && o2[0])
                        {lkTag[mLk], lkXl[mLk]} = {mTag, mXl};
                    else if (wr)
                    begin
                        mLat = 1;
                        mainTag[s] = mTag;
                        mainXl[s] = mXl & ~{31'h0, mWay};
                    end
                default:
                    expQ.push_back(32'h0);
            endcase
        end
        else
            expQ.push_back(32'h0);
    endtask
    // One coprocessor op; offered for one cycle, then wait for completion
    task automatic op(input logic wr, input logic [2:0] o1, input logic [3:0] crm, input logic [2:0] o2,
                      input logic [31:0] d);
        int n;
        n = 0;
        model(wr, o1, crm, o2, d);
        @(posedge clk);
        #1;
        {copValid, copWrite, copOpcode1, copCrn, copCrm, copOpcode2, copWdata} = {1'b1, wr, o1, 4'hF, crm, o2, d};
        @(posedge clk);
        #1;
        copValid = 1'b0;
        checkVal(copReady, mLat == 0, "ready while busy");
        while (copDone !== 1'b1 && n < 10)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        checkVal(n < 10, 1, "no completion");
        checkVal(n, mLat, "completion latency");
        if (expQ.size() > 0)
            checkVal(copRdata, expQ.pop_front(), "model read data");
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        {copValid, copWrite, copOpcode1, copCrn, copCrm, copOpcode2, copWdata} = '0;
        resetN = 1'b0;
        repeat (3) @(posedge clk);
        #1 resetN = 1'b1;
        checkVal(ramOe, 1, "output enable");
        // Every size and permission code, random way, index and junk in zero fields
        for (int i = 0; i < 5; i++)
        begin
            r = rnd();
            way = r[0];
            idx = r[5:1];
            t1 = {2'b10, r[6]};
            tag = rnd() | 32'h0000_0010;
            xl = rnd();
            tag[3:0] = sizes[i];
            xl[3:2] = i[1:0];
            op(1, 0, 1, 0, {way, 31'h0} | (rnd() & 32'h7FFF_83FF) | {17'h0, idx, 10'h000});
            op(1, t1, 3, 0, tag);
            op(1, t1, 5, 0, xl);
            op(1, t1, 7, 0, 0);
            ent = {tag[31:10], tag[3:0], xl[31:10], xl[7:0]};
            checkVal(capBus, {ent, ent}, "write bus");
            checkVal(capLane, way ? 4'hC : 4'h3, "lanes");
            checkVal(capIdx, idx, "index");
            op(0, t1, 2, 0, 0);
            checkVal(copRdata, {tag[31:10], 6'h1, tag[3:0]}, "tag read");
            op(0, t1, 4, 0, 0);
            checkVal(copRdata, {xl[31:10], 2'h0, xl[7:1], xl[0] & !way}, "translation read");
        end
        r = rnd();
        lk = r[2:0];
        op(1, 0, 1, 0, {3'h0, lk, 26'h0});
        op(0, 0, 1, 0, 0);
        op(1, 4, 3, 1, tag);
        op(1, 5, 5, 1, xl);
        op(1, 4, 7, 1, 0);
        op(0, 5, 2, 1, 0);
        checkVal(copRdata, {tag[31:10], 5'h0, tag[4:0]}, "lockdown tag");
        op(0, 4, 4, 1, 0);
        checkVal(copRdata, {xl[31:10], 2'h0, xl[7:0]}, "lockdown translation");
        op(0, 4, 6, 0, 0);
        checkVal(copRdata, 0, "undecoded op");
        op(0, 7, 1, 0, 0);
        final_report();
    end
endmodule
`default_nettype wire
